/* File: mgc_regs.sv */
// mixer gain control register bank with decoded analog settings
// Functional notes
// R1: boost bit adds 20 dB to microphone
// R2: microphone mute silences regardless of gain code
// R3: line left code 5 bits, default muted
// R4: line mute bit silences line input
// R5: pcm left code 5 bits, default muted
// R6: pcm mute bit silences pcm output
// R7: code 00000 +12, 01000 0, mute infinite
// R8: left and right record sources independent
// R9: record select resets to microphone, zero
// R10: record gain 4 bits, 1.5 dB steps
// R11: record mute bit attenuates adc input fully
// R12: phone, cd, video, aux have mute bit 15
// R13: reserved bits read zero, ignore writes
// R14: odd index aliases next lower even index
// R15: any reset register write restores defaults
`timescale 1ns/10ps
module mgc_regs (
  input  wire logic                                       i_clk_sys,
  input  wire logic                                       i_rst,
  input  wire mgc_pkg::mgc_cmd_type                       i_cmd,
  output logic                                            o_rd_valid,
  output logic [15:0]                                     o_rd_data,
  output mgc_pkg::mgc_mono_type                           o_phone,
  output mgc_pkg::mgc_mono_type                           o_mic,
  output mgc_pkg::mgc_stereo_type [mgc_pkg::NUM_STEREO-1:0] o_stereo,
  output mgc_pkg::mgc_record_type                         o_record
);

  logic [15:0] regs [mgc_pkg::NUM_REGS];
  logic [15:0] next_rd_data;

  // command decode; the low index bit is dropped so odd indices alias
  wire logic [6:0] even_idx  = {i_cmd.index[6:1], 1'b0}; // see R14
  wire logic       wr_hit    = i_cmd.valid & ~i_cmd.read;
  wire logic       rd_hit    = i_cmd.valid & i_cmd.read;
  wire logic       reset_hit = wr_hit & (even_idx == mgc_pkg::IDX_RESET); // see R15
  wire logic       in_range  = (even_idx >= mgc_pkg::IDX_PHONE) &&
                               (even_idx <= mgc_pkg::IDX_REC_GN);
  wire logic [6:0] off       = even_idx - mgc_pkg::IDX_PHONE;
  wire logic [3:0] slot      = off[4:1];

  // one storage word per slot; writes are masked so reserved bits stay zero
  for (genvar g = 0; g < mgc_pkg::NUM_REGS; g++) begin : g_reg
    wire logic sel = wr_hit & in_range & (slot == 4'(g));
    always_ff @(posedge i_clk_sys) begin
      if (i_rst || reset_hit) begin
        regs[g] <= mgc_pkg::RST_TABLE[g]; // see R15 R9 R3 R5
      end else if (sel) begin
        regs[g] <= i_cmd.data & mgc_pkg::MASK_TABLE[g]; // see R13
      end
    end
  end

  // read mux; unmapped and reset-register reads return zero since the
  // identification word belongs to the link controller, not this bank
  always_comb begin
    next_rd_data = 16'h0000;
    if (in_range) begin
      next_rd_data = regs[slot]; // see R13 R14
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 16'h0000;
    end else begin
      o_rd_valid <= rd_hit;
      o_rd_data  <= rd_hit ? next_rd_data : o_rd_data;
    end
  end

  // mono source decode; mute wins over any gain code
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_phone <= '0;
      o_mic   <= '0;
    end else begin
      o_phone.silence <= regs[mgc_pkg::SLOT_PHONE][mgc_pkg::MUTE_BIT]; // see R12 R7
      o_phone.boost   <= 1'b0;
      o_phone.code    <= regs[mgc_pkg::SLOT_PHONE][4:0];
      o_mic.silence   <= regs[mgc_pkg::SLOT_MIC][mgc_pkg::MUTE_BIT]; // see R2
      o_mic.boost     <= regs[mgc_pkg::SLOT_MIC][mgc_pkg::BOOST_BIT]; // see R1
      o_mic.code      <= regs[mgc_pkg::SLOT_MIC][4:0];
    end
  end

  // stereo sources: line, cd, video, aux, pcm in that order
  for (genvar k = 0; k < mgc_pkg::NUM_STEREO; k++) begin : g_st
    wire logic [15:0] w = regs[mgc_pkg::SLOT_STEREO0 + k];
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        o_stereo[k] <= '0;
      end else begin
        o_stereo[k].silence    <= w[mgc_pkg::MUTE_BIT]; // see R4 R6 R7 R12
        o_stereo[k].left_code  <= w[mgc_pkg::LEFT_LSB +: 5]; // see R3 R5
        o_stereo[k].right_code <= w[mgc_pkg::RIGHT_LSB +: 5];
      end
    end
  end

  // record path; each adc channel follows its own selector
  wire logic [15:0] rs = regs[mgc_pkg::SLOT_REC_SEL];
  wire logic [15:0] rg = regs[mgc_pkg::SLOT_REC_GN];
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_record <= '0;
    end else begin
      o_record.left_src   <= rs[mgc_pkg::LEFT_LSB +: 3]; // see R8
      o_record.right_src  <= rs[mgc_pkg::RIGHT_LSB +: 3]; // see R8
      o_record.input_mute <= rg[mgc_pkg::MUTE_BIT]; // see R11
      o_record.left_gain  <= rg[mgc_pkg::LEFT_LSB +: 4]; // see R10
      o_record.right_gain <= rg[mgc_pkg::RIGHT_LSB +: 4]; // see R10
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // the low index bit is ignored here too, so odd-index writes are seen
  sequence s_write(logic [6:0] idx);
    i_cmd.valid && !i_cmd.read && (i_cmd.index[6:1] == idx[6:1]);
  endsequence

  sequence s_reset_write;
    i_cmd.valid && !i_cmd.read && (i_cmd.index[6:1] == 6'h00);
  endsequence

  a_reset_restores_defaults: assert property ( // see R15
    s_reset_write |=> ##1 (o_stereo[0].silence && o_stereo[0].left_code == 5'h08 &&
                           o_mic.silence && o_record.input_mute))
    else $error("register reset did not restore mixer defaults");

  a_rec_select_reset: assert property ( // see R9
    s_reset_write |=> ##1 (o_record.left_src == mgc_pkg::SRC_MIC &&
                           o_record.right_src == mgc_pkg::SRC_MIC))
    else $error("record select not microphone after reset write");

  a_odd_index_alias: assert property ( // see R14
    (i_cmd.valid && !i_cmd.read && i_cmd.index == 7'h11 && !i_cmd.data[15])
      |=> ##1 (!o_stereo[0].silence && o_stereo[0].left_code == $past(i_cmd.data[12:8], 2)))
    else $error("odd index write missed the even register");

  a_mic_boost_follow: assert property ( // see R1
    s_write(mgc_pkg::IDX_MIC) |=> ##1 (o_mic.boost == $past(i_cmd.data[6], 2)))
    else $error("microphone boost does not follow its bit");

  a_mic_mute_silence: assert property ( // see R2
    s_write(mgc_pkg::IDX_MIC) |=> ##1
      (o_mic.silence == $past(i_cmd.data[15], 2) && o_mic.code == $past(i_cmd.data[4:0], 2)))
    else $error("microphone mute not applied");

  a_pcm_code_mute: assert property ( // see R5 R6 R7
    s_write(mgc_pkg::IDX_PCM) |=> ##1 (o_stereo[4].silence == $past(i_cmd.data[15], 2) &&
                                       o_stereo[4].left_code == $past(i_cmd.data[12:8], 2)))
    else $error("pcm output setting wrong");

  a_line_width_mute: assert property ( // see R3 R4
    s_write(mgc_pkg::IDX_LINE) |=> ##1 (o_stereo[0].silence == $past(i_cmd.data[15], 2) &&
                                        o_stereo[0].right_code == $past(i_cmd.data[4:0], 2)))
    else $error("line input setting wrong");

  a_phone_mute_bit: assert property ( // see R12
    s_write(mgc_pkg::IDX_PHONE) |=> ##1 (o_phone.silence == $past(i_cmd.data[15], 2)))
    else $error("phone mute not at bit 15");

  a_rec_sel_split: assert property ( // see R8
    s_write(mgc_pkg::IDX_REC_SEL) |=> ##1 (o_record.left_src == $past(i_cmd.data[10:8], 2) &&
                                           o_record.right_src == $past(i_cmd.data[2:0], 2)))
    else $error("record selectors not independent");

  a_rec_gain_mute: assert property ( // see R10 R11
    s_write(mgc_pkg::IDX_REC_GN) |=> ##1 (o_record.input_mute == $past(i_cmd.data[15], 2) &&
                                          o_record.left_gain == $past(i_cmd.data[11:8], 2)))
    else $error("record gain or mute wrong");

  a_reserved_read_zero: assert property ( // see R13
    (rd_hit && in_range) |=> (o_rd_valid &&
      (o_rd_data & ~mgc_pkg::MASK_TABLE[$past(slot)]) == 16'h0000))
    else $error("reserved bits read back nonzero");

  // cd channel carries both codes and its own mute
  a_cd_input_setting: assert property ( // see R12 R7
    s_write(mgc_pkg::IDX_CD) |=> ##1 (o_stereo[1].silence == $past(i_cmd.data[15], 2) &&
                                      o_stereo[1].left_code == $past(i_cmd.data[12:8], 2) &&
                                      o_stereo[1].right_code == $past(i_cmd.data[4:0], 2)))
    else $error("cd input setting wrong");

  // video channel carries both codes and its own mute
  a_video_input_setting: assert property ( // see R12
    s_write(mgc_pkg::IDX_VIDEO) |=> ##1 (o_stereo[2].silence == $past(i_cmd.data[15], 2) &&
                                         o_stereo[2].left_code == $past(i_cmd.data[12:8], 2) &&
                                         o_stereo[2].right_code == $past(i_cmd.data[4:0], 2)))
    else $error("video input setting wrong");

  // auxiliary channel carries both codes and its own mute
  a_aux_input_setting: assert property ( // see R12
    s_write(mgc_pkg::IDX_AUX) |=> ##1 (o_stereo[3].silence == $past(i_cmd.data[15], 2) &&
                                       o_stereo[3].left_code == $past(i_cmd.data[12:8], 2) &&
                                       o_stereo[3].right_code == $past(i_cmd.data[4:0], 2)))
    else $error("aux input setting wrong");

  // pcm right code sits in the low field
  a_pcm_right_code: assert property ( // see R5
    s_write(mgc_pkg::IDX_PCM) |=> ##1
      (o_stereo[4].right_code == $past(i_cmd.data[4:0], 2)))
    else $error("pcm right code wrong");

  // line left code sits in the high field
  a_line_left_code: assert property ( // see R3
    s_write(mgc_pkg::IDX_LINE) |=> ##1
      (o_stereo[0].left_code == $past(i_cmd.data[12:8], 2)))
    else $error("line left code wrong");

  // clearing the line mute must release the channel
  a_line_mute_clear: assert property ( // see R4
    (s_write(mgc_pkg::IDX_LINE) and !i_cmd.data[15]) |=> ##1 !o_stereo[0].silence)
    else $error("line mute did not clear");

  // setting the pcm mute must silence the channel
  a_pcm_mute_set: assert property ( // see R6
    (s_write(mgc_pkg::IDX_PCM) and i_cmd.data[15]) |=> ##1 o_stereo[4].silence)
    else $error("pcm mute did not silence");

  // phone gain code follows the low five bits
  a_phone_code_follow: assert property ( // see R12
    s_write(mgc_pkg::IDX_PHONE) |=> ##1 (o_phone.code == $past(i_cmd.data[4:0], 2)))
    else $error("phone code wrong");

  // right record gain sits in the low nibble
  a_rec_right_gain: assert property ( // see R10
    s_write(mgc_pkg::IDX_REC_GN) |=> ##1
      (o_record.right_gain == $past(i_cmd.data[3:0], 2)))
    else $error("record right gain wrong");

  // every read gets exactly one answer pulse
  a_read_valid_pulse: assert property ( // see R13
    rd_hit |=> o_rd_valid)
    else $error("read not answered");

  // writes never raise the read answer
  a_write_no_answer: assert property ( // see R13
    wr_hit |=> !o_rd_valid)
    else $error("write produced a read answer");

  // read word holds between reads so a slow taker still sees it
  a_read_data_hold: assert property ( // see R13
    !rd_hit |=> $stable(o_rd_data))
    else $error("read data changed without a read");

  // unmapped and reset-register reads return zero
  a_unmapped_read_zero: assert property ( // see R13
    (rd_hit && !in_range) |=> (o_rd_data == 16'h0000))
    else $error("unmapped read not zero");

  // pcm default is 0 dB both sides, muted
  a_reset_pcm_default: assert property ( // see R5
    s_reset_write |=> ##1 (o_stereo[4].silence && o_stereo[4].left_code == 5'h08 &&
                           o_stereo[4].right_code == 5'h08))
    else $error("pcm default wrong after reset write");

  // line default is 0 dB both sides, muted
  a_reset_line_default: assert property ( // see R3
    s_reset_write |=> ##1 (o_stereo[0].silence && o_stereo[0].right_code == 5'h08))
    else $error("line default wrong after reset write");

  // phone default is 0 dB, muted, no boost
  a_reset_phone_default: assert property ( // see R12
    s_reset_write |=> ##1 (o_phone.silence && o_phone.code == 5'h08 && !o_phone.boost))
    else $error("phone default wrong after reset write");

  // microphone default has boost off
  a_reset_mic_default: assert property ( // see R1
    s_reset_write |=> ##1 (!o_mic.boost && o_mic.code == 5'h08))
    else $error("mic default wrong after reset write");

  // record gain default is 0 dB on both channels
  a_reset_rec_gain: assert property ( // see R10 R11
    s_reset_write |=> ##1 (o_record.left_gain == 4'h0 && o_record.right_gain == 4'h0))
    else $error("record gain default wrong after reset write");

  // cd, video and aux come back muted
  a_reset_other_mutes: assert property ( // see R12
    s_reset_write |=> ##1 (o_stereo[1].silence && o_stereo[2].silence &&
                           o_stereo[3].silence))
    else $error("input mutes not restored");

  // a register reset is a write, so no read answer follows it
  a_reset_no_answer: assert property ( // see R15
    s_reset_write |=> !o_rd_valid)
    else $error("reset write produced a read answer");

endmodule

/* File: mgc_pkg.sv */
// mixer gain control register bank: constants, register map and carrier types
package mgc_pkg;

  localparam int          NUM_REGS   = 9;
  localparam int          NUM_STEREO = 5;

  // register indices on the serial link command address
  localparam logic [6:0]  IDX_RESET   = 7'h00;
  localparam logic [6:0]  IDX_PHONE   = 7'h0C;
  localparam logic [6:0]  IDX_MIC     = 7'h0E;
  localparam logic [6:0]  IDX_LINE    = 7'h10;
  localparam logic [6:0]  IDX_CD      = 7'h12;
  localparam logic [6:0]  IDX_VIDEO   = 7'h14;
  localparam logic [6:0]  IDX_AUX     = 7'h16;
  localparam logic [6:0]  IDX_PCM     = 7'h18;
  localparam logic [6:0]  IDX_REC_SEL = 7'h1A;
  localparam logic [6:0]  IDX_REC_GN  = 7'h1C;

  // slot numbers inside the bank
  localparam int          SLOT_PHONE   = 0;
  localparam int          SLOT_MIC     = 1;
  localparam int          SLOT_STEREO0 = 2;
  localparam int          SLOT_REC_SEL = 7;
  localparam int          SLOT_REC_GN  = 8;

  // field positions
  localparam int          MUTE_BIT   = 15;
  localparam int          BOOST_BIT  = 6;
  localparam int          LEFT_LSB   = 8;
  localparam int          RIGHT_LSB  = 0;

  // reset values, slot 8 first
  localparam logic [NUM_REGS-1:0][15:0] RST_TABLE = {
    16'h8000, 16'h0000, 16'h8808, 16'h8808, 16'h8808,
    16'h8808, 16'h8808, 16'h8008, 16'h8008};

  // writable bits; everything else is reserved and reads zero
  localparam logic [NUM_REGS-1:0][15:0] MASK_TABLE = {
    16'h8F0F, 16'h0707, 16'h9F1F, 16'h9F1F, 16'h9F1F,
    16'h9F1F, 16'h9F1F, 16'h805F, 16'h801F};

  // gain coding of the 5-bit mixer codes, 1.5 dB per step
  localparam logic [4:0]  CODE_PLUS12 = 5'h00;
  localparam logic [4:0]  CODE_0DB    = 5'h08;
  localparam logic [4:0]  CODE_MIN    = 5'h1F;
  localparam int          STEP_MDB    = 1500;
  localparam int          BOOST_MDB   = 20000;
  localparam logic [3:0]  REC_CODE_MAX = 4'hF;
  localparam logic [2:0]  SRC_MIC     = 3'h0;

  typedef struct packed {
    logic       silence;
    logic [4:0] left_code;
    logic [4:0] right_code;
  } mgc_stereo_type;

  typedef struct packed {
    logic       silence;
    logic       boost;
    logic [4:0] code;
  } mgc_mono_type;

  typedef struct packed {
    logic [2:0] left_src;
    logic [2:0] right_src;
    logic       input_mute;
    logic [3:0] left_gain;
    logic [3:0] right_gain;
  } mgc_record_type;

  typedef struct packed {
    logic       valid;
    logic       read;
    logic [6:0] index;
    logic [15:0] data;
  } mgc_cmd_type;

endpackage

/* File: mgc_ctrl_model.sv */
// link controller model issuing register commands to the bank
`timescale 1ns/10ps
module mgc_ctrl_model (
  input  wire logic            i_clk_sys,
  output mgc_pkg::mgc_cmd_type o_cmd
);
  initial o_cmd = '0;

  // one command per edge; back to back calls keep valid high
  task automatic issue(input logic rd, input logic [6:0] idx, input logic [15:0] d);
    @(posedge i_clk_sys);
    o_cmd <= '{1'b1, rd, idx, d};
  endtask

  // a released command bus carries inverted junk, never the last word
  task automatic idle();
    @(posedge i_clk_sys);
    o_cmd <= '{1'b0, ~o_cmd.read, ~o_cmd.index, ~o_cmd.data};
  endtask
endmodule

/* File: mixer_gain_control_registers_tb.sv */
// self-checking bench for the mixer gain control register bank
`timescale 1ns/10ps
module mixer_gain_control_registers_tb;
  logic                          i_clk_sys;
  logic                          i_rst;
  mgc_pkg::mgc_cmd_type          cmd;
  logic                          rd_valid;
  logic [15:0]                   rd_data;
  mgc_pkg::mgc_mono_type         phone;
  mgc_pkg::mgc_mono_type         mic;
  mgc_pkg::mgc_stereo_type [4:0] stereo;
  mgc_pkg::mgc_record_type       rec;
  int                            err_total = 0;
  int                            checks_done = 0;
  logic [15:0]                   expq[$];
  logic [15:0]                   wv[9];
  logic [15:0]                   em[9];
  logic [15:0] dflt[9] = '{16'h8008, 16'h8008, 16'h8808, 16'h8808, 16'h8808,
                           16'h8808, 16'h8808, 16'h0000, 16'h8000};
  logic [15:0] msk[9]  = '{16'h801F, 16'h805F, 16'h9F1F, 16'h9F1F, 16'h9F1F,
                           16'h9F1F, 16'h9F1F, 16'h0707, 16'h8F0F};

  mgc_ctrl_model i_ctrl (.i_clk_sys(i_clk_sys), .o_cmd(cmd));

  mgc_regs i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd(cmd), .o_rd_valid(rd_valid),
    .o_rd_data(rd_data), .o_phone(phone), .o_mic(mic), .o_stereo(stereo), .o_record(rec));

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // decoded settings against the register words they came from
  task automatic chk_set(input logic [15:0] w[9]);
    chk("phone", 16'({phone.silence, phone.boost, phone.code}), 16'({w[0][15], 1'b0, w[0][4:0]}));
    chk("mic", 16'({mic.silence, mic.boost, mic.code}), 16'({w[1][15], w[1][6], w[1][4:0]}));
    for (int i = 0; i < 5; i++) begin
      chk("stereo", 16'(stereo[i]), 16'({w[i+2][15], w[i+2][12:8], w[i+2][4:0]}));
    end
    chk("record", 16'(rec), 16'({w[7][10:8], w[7][2:0], w[8][15], w[8][11:8], w[8][3:0]}));
  endtask

  // back to back reads of all slots plus the reset and an unmapped index
  task automatic read_all(input logic [15:0] w[9]);
    for (int i = 0; i < 9; i++) begin
      expq.push_back(w[i]);
      i_ctrl.issue(1'b1, 7'(12 + 2 * i), 16'($urandom));
    end
    expq.push_back(16'h0000);
    i_ctrl.issue(1'b1, 7'h00, 16'h0000);
    expq.push_back(16'h0000);
    i_ctrl.issue(1'b1, 7'h1F, 16'h0000);
    i_ctrl.idle();
    repeat (3) @(posedge i_clk_sys);
  endtask

  // read answers settle by the falling edge; oldest note is compared
  always @(negedge i_clk_sys) begin
    if (rd_valid === 1'b1) begin
      chk("read", rd_data, expq.pop_front());
    end
  end

  // free running 250 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end

  // watchdog well past the under one hundred cycles the sequence needs
  initial begin
    #8000;
    err_total++;
    finish_test();
  end

  // main sequence
  initial begin
    void'($urandom(68814));
    i_rst = 1'b1;
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    chk_set(dflt);
    read_all(dflt);
    // random words through odd indices, junk to an unmapped slot
    for (int i = 0; i < 9; i++) begin
      wv[i] = 16'($urandom);
      em[i] = wv[i] & msk[i];
      i_ctrl.issue(1'b0, 7'(13 + 2 * i), wv[i]);
    end
    i_ctrl.issue(1'b0, 7'h1E, 16'hFFFF);
    i_ctrl.idle();
    repeat (3) @(posedge i_clk_sys);
    chk_set(em);
    read_all(em);
    // register reset through the odd alias of index zero
    i_ctrl.issue(1'b0, 7'h01, 16'($urandom));
    i_ctrl.idle();
    repeat (3) @(posedge i_clk_sys);
    chk_set(dflt);
    read_all(dflt);
    chk("pending", 16'(expq.size()), 16'h0000);
    finish_test();
  end
endmodule
